// ### rtl/bcd_recov_unit.sv
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - condition code sits in recovery word bits 00 and 01.
// - bit 02 debit/credit symbol seen; bit 03 zero suppression running.
// - load instruction reloads condition code and all recovery state from storage.
// - bit 04 marks floating sign operation in progress during edit.
// - bits 05, 06, 07 mark forced dollar, plus and asterisk.
// - bit 08 marks a forced floating character.
// - bit 10 marks unlike signs on magnitude add/subtract or bad edit sign.
// - bit 09 operand is zero; bit 11 interrupt hit during unit operation.
// - bits 12 to 23 hold processed count of first operand field.
// - load traps with unit disabled, but is a no-op in monitor state.
// - store is opcode 70 sub-code 7 with unindexed 18-bit address.
// - store writes current conditions using the same layout load reads.
// - store leaves the internal conditions unchanged.
// - store traps with unit disabled, but is a no-op in monitor state.
module bcd_recov_unit
	import bcd_recov_pkg::*;
(
	// clock and reset
	input  wire logic                      hclk,
	input  wire logic                      hresetn,
	// ahb-lite slave
	input  wire logic                      hsel,
	input  wire logic [7:0]                haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic      [31:0]               hrdata,
	output logic                           hreadyout,
	output logic                           hresp,
	// instruction from the decoder
	input  wire logic                      instr_valid,
	input  wire bcd_recov_pkg::instr_t     instr,
	output logic                           instr_ready,
	output logic                           instr_done,
	output logic                           instr_trap,
	// storage port
	output logic                           mem_valid,
	output bcd_recov_pkg::mem_req_t        mem_req,
	input  wire logic                      mem_ack,
	input  wire logic [23:0]               mem_rdata,
	// live state from and to the arithmetic/edit datapath
	input  wire logic                      unit_upd,
	input  wire bcd_recov_pkg::recov_word_t unit_word,
	output bcd_recov_pkg::recov_word_t     recov_state
);
	import bcd_recov_pkg::*;

	seq_state_t  state_ff, nxt_state;
	recov_word_t recov_ff, nxt_recov;
	mem_req_t    req_ff, nxt_req;
	logic [1:0]  ctrl_ff, nxt_ctrl;
	logic [4:1]  stat_ff, nxt_stat;
	logic        done_ff, nxt_done;
	logic        trap_ff, nxt_trap;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        wr_pend_ff, nxt_wr_pend;
	logic [7:0]  wr_addr_ff, nxt_wr_addr;

	logic        is_recov;
	logic        is_load;
	logic        is_store;
	logic        take;
	logic        ahb_go;
	logic        unit_on;
	logic        monitor;
	logic [4:1]  stat_set;
	logic [4:1]  stat_clr;

	// decode of the instruction handed in
	assign is_recov = instr.opcode == OP_RECOV;
	assign is_load  = is_recov && (instr.subcode == SUB_LOAD);
	assign is_store = is_recov && (instr.subcode == SUB_STORE);
	assign take     = instr_valid && instr_ready;
	assign unit_on  = ctrl_ff[CTRL_ENABLE];
	assign monitor  = ctrl_ff[CTRL_MONITOR];
	assign ahb_go   = hsel && hready && htrans[1];

	// handshake outputs, combinational by design
	assign instr_ready = state_ff == ST_IDLE;
	assign mem_valid   = state_ff != ST_IDLE;
	assign hreadyout   = 1'b1;
	assign hresp       = 1'b0;

	// registered outputs
	assign mem_req     = req_ff;
	assign recov_state = recov_ff;
	assign instr_done  = done_ff;
	assign instr_trap  = trap_ff;
	assign hrdata      = rdata_ff;

	// sequencer and recovery state next values
	always_comb begin
		nxt_state = state_ff;
		nxt_recov = recov_ff;
		nxt_req   = req_ff;
		nxt_done  = 1'b0;
		nxt_trap  = 1'b0;
		stat_set  = 4'h0;
		// datapath keeps the live word current between saves
		if (unit_upd) begin
			nxt_recov = unit_word;
		end
		case (state_ff)
			ST_IDLE: begin
				if (take && (is_load || is_store)) begin
					if (!unit_on && monitor) begin
						// disabled in monitor state: quietly skip
						nxt_done = 1'b1;
						stat_set[STAT_NOP] = 1'b1;
					end else if (!unit_on) begin
						nxt_trap = 1'b1;
						stat_set[STAT_TRAP] = 1'b1;
					end else if (is_store) begin
						// address used as given, never indexed
						nxt_req.we    = 1'b1;
						nxt_req.addr  = instr.addr;
						nxt_req.wdata = nxt_recov;
						nxt_state     = ST_STORE;
					end else begin
						nxt_req.we    = 1'b0;
						nxt_req.addr  = instr.addr;
						nxt_req.wdata = RECOV_RESET;
						nxt_state     = ST_LOAD;
					end
				end
			end
			ST_LOAD: begin
				if (mem_ack) begin
					// storage wins over a datapath update in the same cycle
					nxt_recov = recov_word_t'(mem_rdata);
					nxt_done  = 1'b1;
					nxt_state = ST_IDLE;
					stat_set[STAT_LOADED] = 1'b1;
				end
			end
			ST_STORE: begin
				if (mem_ack) begin
					// live word is kept, not cleared, after the save
					nxt_done  = 1'b1;
					nxt_state = ST_IDLE;
					stat_set[STAT_STORED] = 1'b1;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= ST_IDLE;
			recov_ff <= recov_word_t'(RECOV_RESET);
			req_ff   <= '0;
			done_ff  <= 1'b0;
			trap_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			recov_ff <= nxt_recov;
			req_ff   <= nxt_req;
			done_ff  <= nxt_done;
			trap_ff  <= nxt_trap;
		end
	end

	// bus slave next values; write data arrives one cycle after address
	always_comb begin
		nxt_wr_pend = ahb_go && hwrite;
		nxt_wr_addr = ahb_go ? haddr : wr_addr_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_rdata   = rdata_ff;
		stat_clr    = 4'h0;
		if (wr_pend_ff) begin
			if (wr_addr_ff == ADDR_CTRL) begin
				nxt_ctrl = hwdata[1:0];
			end else if (wr_addr_ff == ADDR_STATUS) begin
				stat_clr = hwdata[4:1]; // write one to clear
			end
		end
		if (ahb_go && !hwrite) begin
			if (haddr == ADDR_CTRL) begin
				nxt_rdata = {30'h00000000, ctrl_ff};
			end else if (haddr == ADDR_STATE) begin
				nxt_rdata = {8'h00, recov_ff};
			end else if (haddr == ADDR_STATUS) begin
				nxt_rdata = {27'h0000000, stat_ff, state_ff != ST_IDLE};
			end else begin
				nxt_rdata = 32'h00000000; // unmapped reads zero
			end
		end
		// a new event wins over a clear in the same cycle
		nxt_stat = (stat_ff & ~stat_clr) | stat_set;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff    <= CTRL_RESET;
			stat_ff    <= 4'h0;
			rdata_ff   <= 32'h00000000;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			stat_ff    <= nxt_stat;
			rdata_ff   <= nxt_rdata;
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
		end
	end

endmodule : bcd_recov_unit

// ### shared/bcd_recov_pkg.sv
package bcd_recov_pkg;

	// recovery word layout, listed from bit 23 down to bit 00
	typedef struct packed {
		logic [11:0] done_count;    // bits 12-23
		logic        intr_seen;     // bit 11
		logic        sign_bad;      // bit 10
		logic        op_zero;       // bit 09
		logic        float_forced;  // bit 08
		logic        star_forced;   // bit 07
		logic        plus_forced;   // bit 06
		logic        dollar_forced; // bit 05
		logic        float_sign;    // bit 04
		logic        zero_supp;     // bit 03
		logic        debit_credit;  // bit 02
		logic [1:0]  cond_code;     // bits 00-01
	} recov_word_t;

	// instruction as handed over by the decoder
	typedef struct packed {
		logic [5:0]  opcode;
		logic [2:0]  subcode;
		logic [17:0] addr;
	} instr_t;

	// storage port request
	typedef struct packed {
		logic        we;
		logic [17:0] addr;
		logic [23:0] wdata;
	} mem_req_t;

	localparam logic [5:0]  OP_RECOV      = 6'h38;  // octal 70
	localparam logic [2:0]  SUB_STORE     = 3'h7;
	localparam logic [2:0]  SUB_LOAD      = 3'h6;
	localparam int          WORD_W        = 24;

	// register byte addresses
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_STATE    = 8'h04;
	localparam logic [7:0]  ADDR_STATUS   = 8'h08;

	// control field positions
	localparam int          CTRL_ENABLE   = 0;
	localparam int          CTRL_MONITOR  = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h0;

	// status field positions
	localparam int          STAT_BUSY     = 0;
	localparam int          STAT_TRAP     = 1;
	localparam int          STAT_NOP      = 2;
	localparam int          STAT_LOADED   = 3;
	localparam int          STAT_STORED   = 4;

	localparam logic [23:0] RECOV_RESET   = 24'h000000;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LOAD  = 2'b01,
		ST_STORE = 2'b10
	} seq_state_t;

endpackage : bcd_recov_pkg

// ### tb/bcd_recov_chk.sv
`timescale 1ns/10ps
module bcd_recov_chk
	import bcd_recov_pkg::*;
(
	// clock and reset
	input logic                       hclk,
	input logic                       hresetn,
	// instruction port
	input logic                       instr_valid,
	input bcd_recov_pkg::instr_t      instr,
	input logic                       instr_done,
	input logic                       instr_trap,
	// storage port
	input logic                       mem_valid,
	input bcd_recov_pkg::mem_req_t    mem_req,
	input logic                       mem_ack,
	input logic [23:0]                mem_rdata,
	// live recovery state
	input logic                       unit_upd,
	input bcd_recov_pkg::recov_word_t unit_word,
	input bcd_recov_pkg::recov_word_t recov_state
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// request must come from the taken instruction
	req_code_a: assert property ($rose(mem_valid) |->
		$past(instr.opcode) == OP_RECOV && mem_req.addr == $past(instr.addr)
		&& mem_req.we == ($past(instr.subcode) == SUB_STORE)) else $error("bad req");
	store_data_a: assert property ($rose(mem_valid) && mem_req.we |->
		mem_req.wdata == recov_state) else $error("bad store data");
	req_hold_a: assert property (mem_valid && !mem_ack |=>
		mem_valid && $stable(mem_req)) else $error("req moved");
	load_apply_a: assert property (mem_valid && mem_ack && !mem_req.we |=>
		recov_state == $past(mem_rdata)) else $error("load lost");
	store_keep_a: assert property (mem_valid && mem_ack && mem_req.we
		&& !unit_upd |=> $stable(recov_state)) else $error("store cleared");
	ack_done_a: assert property (mem_valid && mem_ack |=>
		instr_done && !mem_valid) else $error("no done");
	trap_cause_a: assert property (instr_trap |-> !mem_valid &&
		$past(instr_valid && instr.opcode == OP_RECOV)) else $error("odd trap");
	upd_live_a: assert property (unit_upd && !mem_ack |=>
		recov_state == $past(unit_word)) else $error("upd lost");
	// main scenarios reached
	cover property (mem_valid && mem_ack && mem_req.we);
	cover property (mem_valid && mem_ack && !mem_req.we);
	cover property (instr_trap);
endmodule : bcd_recov_chk

bind bcd_recov_unit bcd_recov_chk i_bcd_recov_chk (.hclk, .hresetn,
	.instr_valid, .instr, .instr_done, .instr_trap, .mem_valid, .mem_req,
	.mem_ack, .mem_rdata, .unit_upd, .unit_word, .recov_state);

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import bcd_recov_pkg::*;
	// bus and instruction side, idle at time zero
	logic        hclk, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout;
	logic        hresp;
	logic [7:0]  haddr = 8'h0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, r;
	logic        instr_valid = 1'h0, mem_ack = 1'h0, unit_upd = 1'h0;
	logic        instr_ready, instr_done, instr_trap, mem_valid;
	logic [23:0] mem_rdata = 24'h0, wd;
	logic [3:0]  g;
	instr_t      instr = '0;
	mem_req_t    mem_req;
	recov_word_t unit_word = '0, recov_state;
	int          errors, samples_checked;

	bcd_recov_unit i_bcd_recov_unit (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
		.hresp, .instr_valid, .instr, .instr_ready, .instr_done, .instr_trap,
		.mem_valid, .mem_req, .mem_ack, .mem_rdata, .unit_upd, .unit_word,
		.recov_state);

	// free-running clock
	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end

	task close_out;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	// bounded wait for ready; a hang ends the run
	task hold;
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge hclk);
			if (hreadyout === 1'h1)
				break;
		end
		if (n == 20) begin
			errors++;
			close_out;
		end
	endtask : hold

	// single word transfer; read data taken at the data-phase edge
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		hold;
		htrans <= 2'h0;
		hwdata <= d;
		hold;
		r = hrdata;
	endtask : xfer

	// g = {trap, done, storage used, write}; storage acks at once
	task run(input logic [2:0] s, input logic [23:0] d);
		int n;
		g = 4'h0;
		instr <= '{OP_RECOV, s, 18'h2A5A5};
		instr_valid <= 1'h1;
		mem_rdata <= d;
		@(posedge hclk);
		instr_valid <= 1'h0;
		for (n = 0; n < 20 && g[3:2] == 2'h0; n++) begin
			@(posedge hclk);
			g[3:2] = {instr_trap, instr_done};
			if (mem_ack)
				mem_ack <= 1'h0;
			else if (mem_valid) begin
				mem_ack <= 1'h1;
				g[1:0] = {1'h1, mem_req.we};
				wd = mem_req.wdata;
				cmp(mem_req.addr, 32'h2A5A5);
			end
		end
		if (g[3:2] == 2'h0) begin
			errors++;
			close_out;
		end
	endtask : run

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		xfer(1'h1, ADDR_CTRL, 32'h1);
		xfer(1'h0, 8'h0C, 32'h0);
		cmp(r, 32'h0);
		// datapath update, then read back through the state register
		unit_word <= 24'hA5CA96;
		unit_upd <= 1'h1;
		@(posedge hclk);
		unit_upd <= 1'h0;
		xfer(1'h0, ADDR_STATE, 32'h0);
		cmp(r, 32'hA5CA96);
		run(SUB_STORE, 24'h0);
		cmp(g, 4'h7);
		cmp(wd, 24'hA5CA96);
		cmp(recov_state, 24'hA5CA96);
		run(SUB_LOAD, 24'h5A3569);
		cmp(g, 4'h6);
		cmp(recov_state, 24'h5A3569);
		run(SUB_STORE, 24'h0);
		cmp(wd, 24'h5A3569);
		// unit switched off: plain trap, then monitor state no-op
		for (int i = 0; i < 2; i++) begin
			xfer(1'h1, ADDR_CTRL, i << CTRL_MONITOR);
			run(SUB_STORE, 24'h0);
			cmp(g, i ? 4'h4 : 4'h8);
			run(SUB_LOAD, 24'h0);
			cmp(g, i ? 4'h4 : 4'h8);
			cmp(recov_state, 24'h5A3569);
		end
		// sticky status: trap, no-op, loaded, stored all seen, unit idle
		xfer(1'h0, ADDR_STATUS, 32'h0);
		cmp(r, 32'h1E);
		xfer(1'h0, ADDR_CTRL, 32'h0);
		cmp(r, 32'h2);
		// write one to clear, then read back empty
		xfer(1'h1, ADDR_STATUS, 32'h1E);
		xfer(1'h0, ADDR_STATUS, 32'h0);
		cmp(r, 32'h0);
		cmp({hresp, instr_ready}, 32'h1);
		close_out;
	end
endmodule : tb_top
